// ---- psl_defs.vh ----
// Constants for the strap latch, interrupt pin and MII side-band logic
`ifndef PSL_DEFS_VH
`define PSL_DEFS_VH

// ==========================================================
// Register offsets (plain register port, 5-bit address)
`define PSL_REG_CTRL 5'h00
`define PSL_REG_STRAP 5'h19
`define PSL_REG_IRQ 5'h1B
`define PSL_REG_PHYCTL 5'h1F

// ==========================================================
// Field positions
`define PSL_CTRL_DUPLEX_BIT 8
`define PSL_CTRL_ISO_BIT 10
`define PSL_PHYCTL_POL_BIT 9
`define PSL_IRQ_MASK_LSB 8

// ==========================================================
// Reset values
`define PSL_CTRL_RST 16'h0000
`define PSL_PHYCTL_RST 16'h0000
`define PSL_IRQ_MASK_RST 8'h00
`define PSL_ID_HIGH_BITS 2'b00

// ==========================================================
// Interface select codes
`define PSL_IF_MII 3'b000
`define PSL_IF_RMII 3'b001
`define PSL_IF_SMII 3'b010
`define PSL_IF_RSVD0 3'b011
`define PSL_IF_MII_PRE 3'b100
`define PSL_IF_RMII_B2B 3'b101
`define PSL_IF_MII_B2B 3'b110
`define PSL_IF_RSVD1 3'b111

// ==========================================================
// Interrupt event bits
`define PSL_EV_STRAP 0
`define PSL_EV_TX_SOF 1
`define PSL_EV_TX_EOF 2
`define PSL_EV_RX_SOF 3
`define PSL_EV_RX_ERR 4
`define PSL_EV_MDIO_IDLE 5

// ==========================================================
// Timing
`define PSL_CLK_KHZ 10000
`define PSL_STRAP_NS 1000
`define PSL_STRAP_CYC ((`PSL_STRAP_NS * `PSL_CLK_KHZ + 999999) / 1000000)
`define PSL_TXC_HALF_NS 200
`define PSL_TXC_HALF_CYC ((`PSL_TXC_HALF_NS * `PSL_CLK_KHZ) / 1000000)
`define PSL_MDIO_IDLE_CYC 64

`endif

// ---- psl_sync2.v ----
// Two-stage synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none

module psl_sync2 #(
  parameter W = 1
) (
  input wire clk,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  // ==========================================================
  // Stages
  // No reset: straps must be followed while the block is held in reset
  reg [W-1:0] meta_r;

  always @(posedge clk)
  begin
    meta_r <= d;
    q <= meta_r;
  end

endmodule

`default_nettype wire

// ---- psl_irq.v ----
// Sticky interrupt status with mask and polarity-selectable output pin
`timescale 1ns/100ps
`default_nettype none
`include "psl_defs.vh"

module psl_irq #(
  parameter N = 8
) (
  input wire clk,
  input wire rst_n,
  input wire [N-1:0] event_in,
  input wire [N-1:0] clr_in,
  input wire mask_we,
  input wire [N-1:0] mask_in,
  input wire active_high,
  output reg [N-1:0] status_r,
  output reg [N-1:0] mask_r,
  output reg irq_pin_r
);

  // ==========================================================
  // Status and mask
  wire [N-1:0] status_nxt;
  wire pending;

  // A new event in the clearing cycle survives the clear
  assign status_nxt = (status_r & ~clr_in) | event_in;
  assign pending = |(status_r & mask_r);

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      status_r <= {N{1'b0}};
      mask_r <= `PSL_IRQ_MASK_RST;
      irq_pin_r <= 1'b1;
    end
    else
    begin
      status_r <= status_nxt;
      if (mask_we)
      begin
        mask_r <= mask_in;
      end
      irq_pin_r <= active_high ? pending : ~pending;
    end
  end

endmodule

`default_nettype wire

// ---- psl_strap_top.v ----
// Strap capture, shared receive pins, interrupt pin and MII side-band logic
// Operation
// - Receive data 3..1 latch station id 0..2
// - Receive data 0 latches duplex, control bit 8
// - Receive valid latches interface select MSB
// - Receive error latches isolate strap
// - After window, pins drive receive data outward unless isolate is set
// - Interrupt control and status at 1Bh
// - Interrupt pin low active, 1Fh bit 9 flips
// - Management clock from master, data follows it
// - Device sources transmit clock, MAC drives data
// - Strap pins inputs only during reset window
// - Three-bit strap selects interface mode; only the MSB is a pin strap, the low two bits come from IF_LOW_STRAP
// - Station id bits 4 and 3 zero
// - Isolate strap loads control bit 10
`timescale 1ns/100ps
`default_nettype none
`include "psl_defs.vh"

module psl_strap_top #(
  parameter STRAP_CYC = `PSL_STRAP_CYC,
  parameter TXC_HALF_CYC = `PSL_TXC_HALF_CYC,
  parameter MDIO_IDLE_CYC = `PSL_MDIO_IDLE_CYC,
  parameter [1:0] IF_LOW_STRAP = 2'b00
) (
  input wire MCLK,
  input wire RST_N,
  input wire [4:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  input wire [3:0] RXD_I,
  output reg [3:0] RXD_O,
  output reg RXD_OE,
  input wire RXDV_I,
  output reg RXDV_O,
  output reg RXDV_OE,
  input wire RXER_I,
  output reg RXER_O,
  output reg RXER_OE,
  input wire [3:0] RX_DATA_IN,
  input wire RX_VALID_IN,
  input wire RX_ERR_IN,
  input wire MDC,
  input wire MDIO_I,
  output reg MDIO_O,
  output reg MDIO_OE,
  input wire MDIO_TX_BIT,
  input wire MDIO_TX_EN,
  output reg MDIO_RX_BIT,
  output reg MDIO_RX_STB,
  output reg TXC,
  input wire TXEN,
  input wire [3:0] TXD,
  output reg [3:0] TX_NIBBLE,
  output reg TX_NIBBLE_STB,
  output reg TX_ACTIVE,
  output wire [4:0] STATION_ID,
  output reg [2:0] IF_MODE,
  output reg IF_MODE_RSVD,
  output wire DUPLEX,
  output wire ISOLATE,
  output reg STRAP_DONE,
  output wire IRQ_OUT
);

  // ==========================================================
  // State and helpers
  localparam [1:0] ST_STRAP = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;
  localparam [15:0] STRAP_LAST = STRAP_CYC[15:0] - 16'h0001;
  localparam [7:0] TXC_LAST = TXC_HALF_CYC[7:0] - 8'h01;
  localparam [7:0] MDIO_IDLE_LAST = MDIO_IDLE_CYC[7:0] - 8'h01;

  // Reserved interface codes are flagged, not remapped
  function is_rsvd;
    input [2:0] code;
    begin
      is_rsvd = (code == `PSL_IF_RSVD0) || (code == `PSL_IF_RSVD1);
    end
  endfunction

  reg [1:0] state_r;
  reg [15:0] win_cnt_r;
  reg [2:0] id_low_r;
  reg [15:0] ctrl_r;
  reg [15:0] phyctl_r;
  reg [7:0] txc_cnt_r;
  reg mdc_d_r;
  reg [7:0] mdio_idle_r;
  reg mdio_busy_r;
  reg rx_valid_d_r;
  reg [7:0] irq_event;
  reg [7:0] irq_clr;
  wire [7:0] irq_status;
  wire [7:0] irq_mask;
  wire irq_pin;
  wire [12:0] pin_s;
  wire [3:0] rxd_s;
  wire rxdv_s;
  wire rxer_s;
  wire mdc_s;
  wire mdio_s;
  wire txen_s;
  wire [3:0] txd_s;
  wire mdc_rise;
  wire txc_tick;
  wire strap_end;
  wire [2:0] if_code;

  // ==========================================================
  // Pin synchronisers
  psl_sync2 #(
    .W(13)
  ) u_sync (
    .clk(MCLK),
    .d({RXD_I, RXDV_I, RXER_I, MDC, MDIO_I, TXEN, TXD}),
    .q(pin_s)
  );

  assign rxd_s = pin_s[12:9];
  assign rxdv_s = pin_s[8];
  assign rxer_s = pin_s[7];
  assign mdc_s = pin_s[6];
  assign mdio_s = pin_s[5];
  assign txen_s = pin_s[4];
  assign txd_s = pin_s[3:0];

  // ==========================================================
  // Strap window
  // The synchronisers keep running in reset, so the window only has to
  // outlast their latency after release before the levels are taken.
  assign strap_end = (state_r == ST_STRAP) && (win_cnt_r == STRAP_LAST);
  assign if_code = {rxdv_s, IF_LOW_STRAP};

  always @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      state_r <= ST_STRAP;
      win_cnt_r <= 16'h0000;
      id_low_r <= 3'b000;
      IF_MODE <= `PSL_IF_MII;
      IF_MODE_RSVD <= 1'b0;
      STRAP_DONE <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_STRAP:
        begin
          win_cnt_r <= win_cnt_r + 16'h0001;
          if (strap_end)
          begin
            id_low_r <= {rxd_s[1], rxd_s[2], rxd_s[3]};
            IF_MODE <= if_code;
            IF_MODE_RSVD <= is_rsvd(if_code);
            STRAP_DONE <= 1'b1;
            state_r <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          state_r <= ST_RUN;
        end
        default:
        begin
          state_r <= ST_STRAP;
        end
      endcase
    end
  end

  assign STATION_ID = {`PSL_ID_HIGH_BITS, id_low_r};

  // ==========================================================
  // Control registers
  always @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      ctrl_r <= `PSL_CTRL_RST;
      phyctl_r <= `PSL_PHYCTL_RST;
    end
    else
    begin
      if (WR && ADDR == `PSL_REG_PHYCTL)
      begin
        phyctl_r <= WDATA;
      end
      if (strap_end)
      begin
        ctrl_r <= ctrl_r;
        ctrl_r[`PSL_CTRL_DUPLEX_BIT] <= rxd_s[0];
        ctrl_r[`PSL_CTRL_ISO_BIT] <= rxer_s;
      end
      else if (WR && ADDR == `PSL_REG_CTRL)
      begin
        ctrl_r <= WDATA;
      end
    end
  end

  assign DUPLEX = ctrl_r[`PSL_CTRL_DUPLEX_BIT];
  assign ISOLATE = ctrl_r[`PSL_CTRL_ISO_BIT];

  // ==========================================================
  // Shared receive pins
  // Isolate also floats the receive outputs so a second device can share them
  always @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      RXD_O <= 4'h0;
      RXDV_O <= 1'b0;
      RXER_O <= 1'b0;
      RXD_OE <= 1'b0;
      RXDV_OE <= 1'b0;
      RXER_OE <= 1'b0;
      rx_valid_d_r <= 1'b0;
    end
    else
    begin
      RXD_O <= RX_DATA_IN;
      RXDV_O <= RX_VALID_IN;
      RXER_O <= RX_ERR_IN;
      rx_valid_d_r <= RX_VALID_IN;
      RXD_OE <= (state_r == ST_RUN) && !ISOLATE;
      RXDV_OE <= (state_r == ST_RUN) && !ISOLATE;
      RXER_OE <= (state_r == ST_RUN) && !ISOLATE;
    end
  end

  // ==========================================================
  // Management pins
  assign mdc_rise = mdc_s && !mdc_d_r;

  always @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      mdc_d_r <= 1'b0;
      MDIO_O <= 1'b1;
      MDIO_OE <= 1'b0;
      MDIO_RX_BIT <= 1'b0;
      MDIO_RX_STB <= 1'b0;
      mdio_idle_r <= 8'h00;
      mdio_busy_r <= 1'b0;
    end
    else
    begin
      mdc_d_r <= mdc_s;
      MDIO_RX_STB <= 1'b0;
      if (mdc_rise)
      begin
        // Sample and launch on clock rise
        MDIO_RX_BIT <= mdio_s;
        MDIO_RX_STB <= 1'b1;
        MDIO_O <= MDIO_TX_BIT;
        MDIO_OE <= MDIO_TX_EN;
        mdio_idle_r <= 8'h00;
        mdio_busy_r <= 1'b1;
      end
      else if (mdio_busy_r)
      begin
        // A stopped clock ends the frame; release the line
        if (mdio_idle_r == MDIO_IDLE_LAST)
        begin
          mdio_busy_r <= 1'b0;
          MDIO_OE <= 1'b0;
        end
        else
        begin
          mdio_idle_r <= mdio_idle_r + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Transmit clock and transmit inputs
  assign txc_tick = (txc_cnt_r == TXC_LAST);

  always @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      txc_cnt_r <= 8'h00;
      TXC <= 1'b0;
      TX_NIBBLE <= 4'h0;
      TX_NIBBLE_STB <= 1'b0;
      TX_ACTIVE <= 1'b0;
    end
    else
    begin
      TX_NIBBLE_STB <= 1'b0;
      if (txc_tick)
      begin
        txc_cnt_r <= 8'h00;
        TXC <= !TXC;
        if (!TXC)
        begin
          // MAC data taken at clock rise
          TX_ACTIVE <= txen_s;
          if (txen_s)
          begin
            TX_NIBBLE <= txd_s;
            TX_NIBBLE_STB <= 1'b1;
          end
        end
      end
      else
      begin
        txc_cnt_r <= txc_cnt_r + 8'h01;
      end
    end
  end

  // ==========================================================
  // Interrupts
  always @*
  begin
    irq_event = 8'h00;
    irq_event[`PSL_EV_STRAP] = strap_end;
    irq_event[`PSL_EV_TX_SOF] = txc_tick && !TXC && txen_s && !TX_ACTIVE;
    irq_event[`PSL_EV_TX_EOF] = txc_tick && !TXC && !txen_s && TX_ACTIVE;
    irq_event[`PSL_EV_RX_SOF] = RX_VALID_IN && !rx_valid_d_r;
    irq_event[`PSL_EV_RX_ERR] = RX_ERR_IN;
    irq_event[`PSL_EV_MDIO_IDLE] = mdio_busy_r && !mdc_rise && (mdio_idle_r == MDIO_IDLE_LAST);
    irq_clr = 8'h00;
    if (WR && ADDR == `PSL_REG_IRQ)
    begin
      irq_clr = WDATA[7:0];
    end
  end

  psl_irq #(
    .N(8)
  ) u_irq (
    .clk(MCLK),
    .rst_n(RST_N),
    .event_in(irq_event),
    .clr_in(irq_clr),
    .mask_we(WR && ADDR == `PSL_REG_IRQ),
    .mask_in(WDATA[15:8]),
    .active_high(phyctl_r[`PSL_PHYCTL_POL_BIT]),
    .status_r(irq_status),
    .mask_r(irq_mask),
    .irq_pin_r(irq_pin)
  );

  assign IRQ_OUT = irq_pin;

  // ==========================================================
  // Read port
  always @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      RDATA <= 16'h0000;
    end
    else if (!RD)
    begin
      RDATA <= 16'h0000;
    end
    else if (ADDR == `PSL_REG_CTRL)
    begin
      RDATA <= ctrl_r;
    end
    else if (ADDR == `PSL_REG_STRAP)
    begin
      RDATA <= {6'h00, STRAP_DONE, IF_MODE_RSVD, IF_MODE, STATION_ID};
    end
    else if (ADDR == `PSL_REG_IRQ)
    begin
      RDATA <= {irq_mask, irq_status};
    end
    else if (ADDR == `PSL_REG_PHYCTL)
    begin
      RDATA <= phyctl_r;
    end
    else
    begin
      RDATA <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

// ---- psl_strap_monitor.sv ----
// Checker on the strap latch top ports
`timescale 1ns/100ps
`default_nettype none
module psl_strap_monitor (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [3:0] RX_DATA_IN,
  input wire logic [3:0] RXD_O,
  input wire logic RXD_OE,
  input wire logic MDC,
  input wire logic MDIO_RX_STB,
  input wire logic TXC,
  input wire logic TX_NIBBLE_STB,
  input wire logic [4:0] STATION_ID,
  input wire logic [2:0] IF_MODE,
  input wire logic IF_MODE_RSVD,
  input wire logic ISOLATE,
  input wire logic STRAP_DONE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  property p_id_high; STRAP_DONE |-> STATION_ID[4:3] == 2'b00; endproperty
  a_id_high: assert property (p_id_high) else $error("station id high bits set");
  property p_oe_wait; !STRAP_DONE |-> !RXD_OE; endproperty
  a_oe_wait: assert property (p_oe_wait) else $error("pins driven in strap window");
  property p_rsvd; STRAP_DONE |-> IF_MODE_RSVD == (IF_MODE[1:0] == 2'b11); endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved mode flag wrong");
  property p_hold; STRAP_DONE |=> STRAP_DONE && $stable(STATION_ID); endproperty
  a_hold: assert property (p_hold) else $error("latched id changed");
  property p_rx_copy; RXD_OE |-> RXD_O == $past(RX_DATA_IN); endproperty
  a_rx_copy: assert property (p_rx_copy) else $error("receive data not passed");
  property p_iso; RXD_OE |-> !$past(ISOLATE); endproperty
  a_iso: assert property (p_iso) else $error("pins driven while isolated");
  property p_mdc; $rose(MDC) |-> ##[1:4] MDIO_RX_STB; endproperty
  a_mdc: assert property (p_mdc) else $error("management clock rise missed");
  property p_nib; TX_NIBBLE_STB |-> $rose(TXC); endproperty
  a_nib: assert property (p_nib) else $error("nibble strobe off clock rise");
  property p_txc; $rose(TXC) |=> TXC ##1 !TXC; endproperty
  a_txc: assert property (p_txc) else $error("transmit clock period wrong");
endmodule
bind psl_strap_top psl_strap_monitor u_mon (.MCLK, .RST_N, .RX_DATA_IN, .RXD_O, .RXD_OE,
  .MDC, .MDIO_RX_STB, .TXC, .TX_NIBBLE_STB, .STATION_ID, .IF_MODE, .IF_MODE_RSVD,
  .ISOLATE, .STRAP_DONE);
`default_nettype wire

// ---- psl_mac_model.sv ----
// MAC and management master model
`timescale 1ns/100ps
`default_nettype none
module psl_mac_model (
  input wire logic TXC,
  input wire logic MDIO_O,
  input wire logic MDIO_OE,
  output logic TXEN,
  output logic [3:0] TXD,
  output logic MDC,
  output logic MDIO_I
);
  logic m_oe = 1'b0;
  logic m_bit = 1'b0;
  initial
  begin
    TXEN = 1'b0;
    TXD = 4'h0;
    MDC = 1'b0;
  end
  assign MDIO_I = m_oe ? m_bit : (MDIO_OE ? MDIO_O : 1'b1);
  task automatic send(input logic [15:0] d);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge TXC);
      #50;
      TXEN = 1'b1;
      TXD = d[4*i +: 4];
    end
    @(posedge TXC);
    #50;
    TXEN = 1'b0;
    TXD = ~TXD;
  endtask
  task automatic frame(input logic [15:0] d);
    m_oe = 1'b1;
    for (int i = 15; i >= 0; i--)
    begin
      m_bit = d[i];
      #400;
      MDC = 1'b1;
      #400;
      MDC = 1'b0;
    end
    m_oe = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- psl_strap_top_tb_top.sv ----
// Self-checking bench for the strap latch top
`timescale 1ns/100ps
`default_nettype none
`include "psl_defs.vh"
module psl_strap_top_tb_top;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic [4:0] ADDR = 5'h00;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [5:0] s_pin = 6'h00;
  logic [3:0] rx_d = 4'h0;
  logic rx_v = 1'b0;
  logic rx_e = 1'b0;
  logic mt_bit = 1'b0;
  logic rd_q = 1'b0;
  logic mt_en = 1'b0;
  logic [15:0] d;
  int seed = 28737;
  int err_total = 0;
  int num_checks = 0;
  logic [15:0] rq[$];
  logic [15:0] tq[$];
  logic [15:0] mq[$];
  wire [15:0] RDATA;
  wire [3:0] RXD_O, TXD, TX_NIBBLE, RXD_I;
  wire RXD_OE, RXDV_O, RXDV_OE, RXER_O, RXER_OE, RXDV_I, RXER_I, TXC, TXEN, MDC;
  wire MDIO_I, MDIO_O, MDIO_OE, MDIO_RX_BIT, MDIO_RX_STB, TX_NIBBLE_STB, STRAP_DONE, IRQ_OUT;
  wire TX_ACTIVE, DUPLEX, ISOLATE;
  // Strap pulls seen only while the device is not driving
  assign RXD_I = RXD_OE ? RXD_O : s_pin[5:2];
  assign RXDV_I = RXDV_OE ? RXDV_O : s_pin[1];
  assign RXER_I = RXER_OE ? RXER_O : s_pin[0];
  always #50 MCLK = ~MCLK;
  psl_strap_top #(.IF_LOW_STRAP(2'b01)) dut (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RXD_I(RXD_I), .RXD_O(RXD_O),
    .RXD_OE(RXD_OE), .RXDV_I(RXDV_I), .RXDV_O(RXDV_O), .RXDV_OE(RXDV_OE), .RXER_I(RXER_I),
    .RXER_O(RXER_O), .RXER_OE(RXER_OE), .RX_DATA_IN(rx_d), .RX_VALID_IN(rx_v),
    .RX_ERR_IN(rx_e), .MDC(MDC), .MDIO_I(MDIO_I), .MDIO_O(MDIO_O), .MDIO_OE(MDIO_OE),
    .MDIO_TX_BIT(mt_bit), .MDIO_TX_EN(mt_en), .MDIO_RX_BIT(MDIO_RX_BIT),
    .MDIO_RX_STB(MDIO_RX_STB), .TXC(TXC), .TXEN(TXEN), .TXD(TXD), .TX_NIBBLE(TX_NIBBLE),
    .TX_NIBBLE_STB(TX_NIBBLE_STB), .TX_ACTIVE(TX_ACTIVE), .STATION_ID(), .IF_MODE(),
    .IF_MODE_RSVD(), .DUPLEX(DUPLEX), .ISOLATE(ISOLATE), .STRAP_DONE(STRAP_DONE),
    .IRQ_OUT(IRQ_OUT));
  psl_mac_model u_mac (.TXC(TXC), .MDIO_O(MDIO_O), .MDIO_OE(MDIO_OE), .TXEN(TXEN),
    .TXD(TXD), .MDC(MDC), .MDIO_I(MDIO_I));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    rq.push_back(e);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    @(posedge MCLK);
  endtask
  // Receive data wander every cycle; results are compared as they appear
  always @(posedge MCLK)
  begin
    rx_d <= 4'($random(seed));
    rd_q <= RD;
    if (rd_q)
      chk("rdata", RDATA, rq.pop_front());
    if (TX_NIBBLE_STB)
      chk("tx_nibble", TX_NIBBLE, tq.pop_front());
    if (MDIO_RX_STB)
      chk("mdio_bit", {15'h0000, MDIO_RX_BIT}, mq.pop_front());
  end
  task automatic strap_run(input logic [5:0] s);
    int n;
    RST_N <= 1'b0;
    s_pin <= s;
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
    for (n = 0; n < 40 && STRAP_DONE !== 1'b1; n++)
      @(posedge MCLK);
    if (n == 40)
    begin
      err_total++;
      finish_test;
    end
    @(posedge MCLK);
    rd(`PSL_REG_STRAP, {6'h00, 2'b10, s[1], 2'b01, 2'b00, s[3], s[4], s[5]});
    rd(`PSL_REG_CTRL, {5'h00, s[0], 1'b0, s[2], 8'h00});
    chk("rx_oe", {13'h0000, RXD_OE, RXDV_OE, RXER_OE}, {13'h0000, {3{~s[0]}}});
    chk("straps", {14'h0000, DUPLEX, ISOLATE}, {14'h0000, s[2], s[0]});
    $display("strap test ends");
  endtask
  initial
  begin
    #5_000_000;
    err_total++;
    finish_test;
  end
  initial
  begin
    @(posedge MCLK);
    for (int k = 0; k < 4; k++)
      strap_run({5'($random(seed)), k[0] == 1'b0});
    // Interrupt pin polarity, mask and clear
    chk("irq_idle", {15'h0000, IRQ_OUT}, 16'h0001);
    wr(`PSL_REG_IRQ, 16'h0100);
    repeat (3) @(posedge MCLK);
    chk("irq_low", {15'h0000, IRQ_OUT}, 16'h0000);
    wr(`PSL_REG_PHYCTL, 16'h0200);
    repeat (3) @(posedge MCLK);
    chk("irq_high", {15'h0000, IRQ_OUT}, 16'h0001);
    rd(`PSL_REG_PHYCTL, 16'h0200);
    wr(`PSL_REG_IRQ, 16'h0101);
    repeat (3) @(posedge MCLK);
    chk("irq_clear", {15'h0000, IRQ_OUT}, 16'h0000);
    rx_v <= 1'b1;
    rx_e <= 1'b1;
    repeat (4) @(posedge MCLK);
    chk("rx_side", {14'h0000, RXDV_O, RXER_O}, 16'h0003);
    rd(`PSL_REG_IRQ, 16'h0118);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000);
    $display("interrupt test ends");
    // Back-to-back transmit bursts
    for (int b = 0; b < 3; b++)
    begin
      d = 16'($random(seed));
      for (int i = 0; i < 4; i++)
        tq.push_back({12'h000, d[4*i +: 4]});
      u_mac.send(d);
    end
    repeat (8) @(posedge MCLK);
    chk("tx_left", 16'(tq.size()), 16'h0000);
    chk("tx_idle", {15'h0000, TX_ACTIVE}, 16'h0000);
    $display("transmit test ends");
    // Management frame on an unrelated phase
    d = 16'($random(seed));
    mt_bit <= d[0];
    mt_en <= 1'b1;
    for (int i = 15; i >= 0; i--)
      mq.push_back({15'h0000, d[i]});
    #37;
    u_mac.frame(d);
    @(posedge MCLK);
    repeat (8) @(posedge MCLK);
    chk("mdio_left", 16'(mq.size()), 16'h0000);
    chk("mdio_drive", {14'h0000, MDIO_OE, MDIO_O}, {14'h0000, 1'b1, d[0]});
    // A stopped management clock must release the line and flag the idle event
    repeat (70) @(posedge MCLK);
    chk("mdio_release", {15'h0000, MDIO_OE}, 16'h0000);
    // Clearing a bit whose event still stands leaves it set
    wr(`PSL_REG_IRQ, 16'h0110);
    rd(`PSL_REG_IRQ, 16'h013E);
    $display("management test ends");
    finish_test;
  end
endmodule
`default_nettype wire
